// ===== ievr_pkg.sv
// constants for the input event recorder
package ievr_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int MS_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int LOG_EVENTS = 3072;
  localparam int LOG_WORDS = 6144;
  localparam int AC_FACTOR = 4;
  localparam logic [13:0] OFS_CTRL = 14'h0000;
  localparam logic [13:0] OFS_LEVEL = 14'h0010;
  localparam logic [13:0] OFS_TSTAMP = 14'h0120;
  localparam logic [13:0] OFS_MAXCNT = 14'h0122;
  localparam logic [13:0] OFS_COUNT = 14'h0124;
  localparam logic [13:0] OFS_INDEX = 14'h0126;
  localparam logic [13:0] OFS_CHCFG = 14'h0200;
  localparam logic [13:0] OFS_PULSE = 14'h0300;
  localparam logic [13:0] OFS_SWAP = 14'h0802;
  localparam logic [13:0] OFS_EVT_TS = 14'h1000;
  localparam logic [13:0] OFS_EVT_CH = 14'h1002;
  localparam logic [15:0] RST_MAXCNT = 16'h0C00;
  localparam logic [15:0] RST_CHCFG = 16'h0000;
  localparam int CFG_DEB_MSB = 9;
  localparam int CFG_SEL_LSB = 10;
  localparam int CFG_AC = 12;
  localparam int CFG_PCEN = 13;
  localparam int CFG_PRISE = 14;
  localparam int CFG_PIEN = 15;
  localparam int EV_LEVEL_BIT = 8;
  localparam int FLAG_MAX = 0;
  localparam int FLAG_PULSE = 1;
  localparam int FLAG_CHG = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SCAN = 2'b10
  } scan_state_t;
endpackage

// ===== input_event_recorder.sv
// input event recorder: debounce, state change, pulse counters, event log
`timescale 1ns/100ps
module input_event_recorder import ievr_pkg::*; #(
  parameter int CHANNELS = 64,
  parameter int BUF_EVENTS = LOG_EVENTS,
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [CHANNELS-1:0] field_in,
  input wire logic [13:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic host_irq
);
  localparam int CW = $clog2(CHANNELS);
  localparam int SW = $clog2(BUF_EVENTS);
  localparam int TW = $clog2(TICK_CYCLES);

  // event slots must fit the host window, ticks must outlast a scan
  if (CHANNELS < 2 || CHANNELS > 64 || BUF_EVENTS < 2 || BUF_EVENTS > LOG_EVENTS
      || TICK_CYCLES < CHANNELS + 2) begin : g_bad
    $error("input_event_recorder: unsupported parameter values");
  end

  function automatic logic chan_hit(input logic [13:0] a, input logic [13:0] base);
    chan_hit = (a[13:7] == base[13:7]);
  endfunction

  function automatic int mem_at(input logic bank, input logic [SW-1:0] slot);
    mem_at = (bank ? BUF_EVENTS : 0) + int'(slot);
  endfunction

  logic rst_s1_reg, rst_n;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  logic [CHANNELS-1:0] in_s1_reg, in_s2_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= field_in;
      in_s2_reg <= in_s1_reg;
    end
  end

  // millisecond tick and timestamp
  logic [TW-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] tstamp_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 1'b1;
    end
  end
  // one count per tick, host may preset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tstamp_reg <= '0;
    else if (reg_wr && reg_addr == OFS_TSTAMP) tstamp_reg <= reg_wdata;
    else if (tick_reg) tstamp_reg <= tstamp_reg + 16'h0001;
  end

  // host-written configuration
  logic [15:0] cfg_mem [CHANNELS];
  logic [2:0] irq_en_reg;
  logic [15:0] max_reg;
  logic swap;
  assign swap = reg_wr && reg_addr == OFS_SWAP;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
      max_reg <= RST_MAXCNT;
      for (int i = 0; i < CHANNELS; i++) cfg_mem[i] <= RST_CHCFG;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) irq_en_reg <= reg_wdata[2:0];
      if (reg_addr == OFS_MAXCNT) max_reg <= reg_wdata;
      if (chan_hit(reg_addr, OFS_CHCFG) && int'(reg_addr[6:1]) < CHANNELS)
        cfg_mem[reg_addr[6:1]] <= reg_wdata;
    end
  end

  // channel scan after each tick
  scan_state_t state_reg;
  logic [CHANNELS-1:0] samp_reg, stable_reg;
  logic [CW-1:0] ch_reg;
  // one spare bit so four times the longest debounce still fits
  logic [12:0] deb_mem [CHANNELS];
  logic [15:0] pulse_mem [CHANNELS];
  logic [15:0] cfg, pulse_cur;
  logic s, st, accept, ev, pulse_hit;
  logic [12:0] limit, cnt_inc;
  assign cfg = cfg_mem[ch_reg];
  assign s = samp_reg[ch_reg];
  assign st = stable_reg[ch_reg];
  assign pulse_cur = pulse_mem[ch_reg];
  assign cnt_inc = deb_mem[ch_reg] + 13'h0001;
  // ac falling needs four times the time
  assign limit = (cfg[CFG_AC] && !s) ? 13'(AC_FACTOR * (int'(cfg[CFG_DEB_MSB:0]) + 1))
                                     : 13'(int'(cfg[CFG_DEB_MSB:0]) + 1);
  assign accept = (state_reg == ST_SCAN) && (s != st) && (cnt_inc >= limit);
  // 01 rise, 10 fall, 11 both, 00 off
  assign ev = accept && (s ? cfg[CFG_SEL_LSB] : cfg[CFG_SEL_LSB+1]);
  assign pulse_hit = accept && cfg[CFG_PCEN] && (s == cfg[CFG_PRISE]);

  // all inputs captured together, then filtered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      samp_reg <= '0;
      ch_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: if (tick_reg) begin
          samp_reg <= in_s2_reg;
          ch_reg <= '0;
          state_reg <= ST_SCAN;
        end
        ST_SCAN: begin
          ch_reg <= ch_reg + 1'b1;
          if (ch_reg == CW'(CHANNELS - 1)) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // debounced levels kept for the host
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_reg <= '0;
      for (int i = 0; i < CHANNELS; i++) deb_mem[i] <= '0;
    end else if (state_reg == ST_SCAN) begin
      if (accept) stable_reg[ch_reg] <= s;
      deb_mem[ch_reg] <= (s == st || accept) ? 13'h0000 : cnt_inc;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) pulse_mem[i] <= '0;
    end else if (pulse_hit) begin
      pulse_mem[ch_reg] <= pulse_mem[ch_reg] + 16'h0001;
    end
  end

  // event log pointers and counts
  logic bank_reg;
  logic [SW-1:0] slot_reg;
  logic [15:0] count_reg, index_reg, count_next;
  logic [SW-1:0] wr_slot;
  logic wr_bank;
  assign wr_bank = swap ? !bank_reg : bank_reg;
  assign wr_slot = swap ? '0 : slot_reg;
  assign count_next = (swap ? 16'h0000 : (count_reg == 16'(BUF_EVENTS) ? 16'h0000 : count_reg))
                      + 16'h0001;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= 1'b0;
      slot_reg <= '0;
      count_reg <= '0;
      index_reg <= '0;
    end else begin
      // swap copies count to index and clears it
      // recording goes on in the other bank
      if (swap) begin
        bank_reg <= !bank_reg;
        index_reg <= count_reg;
        count_reg <= '0;
        slot_reg <= '0;
      end
      // one event per cycle in scan order
      if (ev) begin
        count_reg <= count_next;
        slot_reg <= (wr_slot == SW'(BUF_EVENTS - 1)) ? '0 : wr_slot + 1'b1;
      end
    end
  end

  logic [15:0] ts_mem [2*BUF_EVENTS];
  logic [15:0] chw_mem [2*BUF_EVENTS];
  logic [SW-1:0] host_slot;
  logic host_evt;
  assign host_slot = SW'((reg_addr - OFS_EVT_TS) >> 2);
  // event n at base plus 4n
  assign host_evt = reg_addr >= OFS_EVT_TS && int'(host_slot) < BUF_EVENTS
                    && (reg_addr - OFS_EVT_TS) < 14'(4 * BUF_EVENTS);
  always_ff @(posedge sys_clk) begin
    if (ev) begin
      ts_mem[mem_at(wr_bank, wr_slot)] <= tstamp_reg;
      chw_mem[mem_at(wr_bank, wr_slot)] <= {7'h00, s, 8'(ch_reg)};
    end else if (reg_wr && host_evt) begin
      if (reg_addr[1]) chw_mem[mem_at(!bank_reg, host_slot)] <= {7'h00, reg_wdata[8:0]};
      else ts_mem[mem_at(!bank_reg, host_slot)] <= reg_wdata;
    end
  end

  // sticky flags and interrupt
  logic [2:0] flags_reg, flags_set;
  // pulse counter wrapped with enable set
  assign flags_set = {ev, pulse_hit && cfg[CFG_PIEN] && pulse_mem[ch_reg] == 16'hFFFF,
                      ev && count_next == max_reg};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flags_reg <= '0;
    else if (reg_wr && reg_addr == OFS_CTRL) flags_reg <= (flags_reg & ~reg_wdata[10:8]) | flags_set;
    else flags_reg <= flags_reg | flags_set;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) host_irq <= 1'b0;
    else host_irq <= |(flags_reg & irq_en_reg);
  end

  // register reads
  logic [63:0] lvl_pad;
  assign lvl_pad = 64'(stable_reg);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= '0;
      if (reg_rd) begin
        if (reg_addr == OFS_CTRL) reg_rdata <= {5'h00, flags_reg, 5'h00, irq_en_reg};
        else if (reg_addr[13:3] == OFS_LEVEL[13:3])
          reg_rdata <= lvl_pad[16*int'(reg_addr[2:1]) +: 16];
        else if (reg_addr == OFS_TSTAMP) reg_rdata <= tstamp_reg;
        else if (reg_addr == OFS_MAXCNT) reg_rdata <= max_reg;
        else if (reg_addr == OFS_COUNT) reg_rdata <= count_reg;
        else if (reg_addr == OFS_INDEX) reg_rdata <= index_reg;
        else if (chan_hit(reg_addr, OFS_CHCFG) && int'(reg_addr[6:1]) < CHANNELS)
          reg_rdata <= cfg_mem[reg_addr[6:1]];
        else if (chan_hit(reg_addr, OFS_PULSE) && int'(reg_addr[6:1]) < CHANNELS)
          reg_rdata <= pulse_mem[reg_addr[6:1]];
        // timestamp at 1000h, channel word at +2
        else if (host_evt)
          reg_rdata <= reg_addr[1] ? chw_mem[mem_at(!bank_reg, host_slot)]
                                   : ts_mem[mem_at(!bank_reg, host_slot)];
      end
    end
  end

  // checks
  chk_count_roll: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev && !swap && count_reg == 16'(BUF_EVENTS) |=> count_reg == 16'h0001)
    else $error("event count did not roll over");
  chk_swap_index: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swap && !ev |=> index_reg == $past(count_reg) && count_reg == 16'h0000
    && bank_reg != $past(bank_reg))
    else $error("swap did not move count to index");
  chk_slot_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev && !swap && slot_reg == SW'(BUF_EVENTS - 1) |=> slot_reg == '0)
    else $error("write slot did not wrap");
  chk_ac_falling: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && !s && cfg[CFG_AC] |-> int'(cnt_inc) >= 4 * (int'(cfg[CFG_DEB_MSB:0]) + 1))
    else $error("ac falling accepted too early");
  chk_tick_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !tick_reg && !(reg_wr && reg_addr == OFS_TSTAMP) |=> $stable(tstamp_reg))
    else $error("timestamp moved without tick");
  chk_tick_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick_reg && !(reg_wr && reg_addr == OFS_TSTAMP)
    |=> tstamp_reg == $past(tstamp_reg) + 16'h0001)
    else $error("timestamp did not advance on tick");
  chk_max_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev && count_next == max_reg |=> flags_reg[FLAG_MAX])
    else $error("maximum count flag not set");
  chk_pulse_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && s != cfg[CFG_PRISE] |=> pulse_mem[$past(ch_reg)] == $past(pulse_cur))
    else $error("pulse counted on wrong direction");
  chk_pulse_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pulse_hit |=> pulse_mem[$past(ch_reg)] == $past(pulse_cur) + 16'h0001)
    else $error("pulse counter did not step");
  chk_irq_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev && irq_en_reg[FLAG_CHG] && !reg_wr |=> ##1 host_irq)
    else $error("change interrupt missing");
  chk_irq_max: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev && count_next == max_reg && irq_en_reg[FLAG_MAX] && !reg_wr |=> ##1 host_irq)
    else $error("maximum count interrupt missing");
  chk_chg_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev |=> flags_reg[FLAG_CHG])
    else $error("change flag not set");
  chk_deb_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    accept && !(cfg[CFG_AC] && !s) |-> int'(cnt_inc) >= int'(cfg[CFG_DEB_MSB:0]) + 1)
    else $error("change accepted before debounce time");
  chk_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000)
    else $error("read port not idle");
endmodule

// ===== ievr_host_model.sv
// bus host model driving the register port
`timescale 1ns/100ps
module ievr_host_model import ievr_pkg::*; (
  input wire logic sys_clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [13:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 14'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released strobes go low, address and data lines show the inverse of the last value
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    release_bus();
  endtask
  // unknown data returned when no answer came
  task automatic rd(input logic [13:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    release_bus();
    d = reg_rvalid ? reg_rdata : 16'hXXXX;
  endtask
  task automatic swap();
    wr(OFS_SWAP, 16'hA5A5);
  endtask
endmodule

// ===== input_event_recorder_tb_top.sv
// testbench for the input event recorder
`timescale 1ns/100ps
module input_event_recorder_tb_top import ievr_pkg::*;;
  localparam int TK = 100;
  typedef struct {logic [13:0] a; logic [15:0] e;} row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [63:0] field_in = 64'h0;
  logic [13:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic host_irq;
  logic [15:0] v;
  logic [15:0] ts0;
  int failures = 0;
  int tests_run = 0;
  row_t rows [9] = '{'{OFS_CTRL, 16'h0000}, '{OFS_LEVEL, 16'h0000},
    '{OFS_MAXCNT, RST_MAXCNT}, '{OFS_COUNT, 16'h0000}, '{OFS_INDEX, 16'h0000},
    '{OFS_CHCFG, RST_CHCFG}, '{OFS_CHCFG + 14'h007E, RST_CHCFG},
    '{OFS_PULSE, 16'h0000}, '{14'h0700, 16'h0000}};
  always #12.5 sys_clk = ~sys_clk;
  input_event_recorder #(.CHANNELS(64), .BUF_EVENTS(16), .TICK_CYCLES(TK)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .field_in(field_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .host_irq(host_irq));
  ievr_host_model host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [13:0] a, input logic [15:0] e);
    host.rd(a, v);
    check(v, e);
  endtask
  task automatic wt(input int n);
    repeat (n * TK) @(posedge sys_clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e); // reset values
    $display("test reset_values done");
    host.rd(OFS_TSTAMP, ts0);
    repeat (10 * TK - 2) @(posedge sys_clk);
    host.rd(OFS_TSTAMP, v);
    check(v - ts0, 16'h000A); // one per tick
    $display("test timestamp done");
    host.wr(OFS_CHCFG + 14'h0006, 16'h6C00);
    host.wr(OFS_CHCFG + 14'h0008, 16'h2800);
    host.wr(OFS_CHCFG + 14'h000A, 16'h0400);
    host.wr(OFS_CTRL, 16'h0004);
    field_in[4:3] = 2'b11;
    wt(3);
    field_in[4:3] = 2'b00;
    wt(3);
    field_in[5] = 1'b1;
    wt(3);
    field_in[5] = 1'b0;
    wt(3);
    rchk(OFS_COUNT, 16'h0004); // select modes
    rchk(OFS_PULSE + 14'h0006, 16'h0001); // one direction
    rchk(OFS_PULSE + 14'h0008, 16'h0001); // falling count
    rchk(OFS_CTRL, 16'h0404); // change flag
    check({15'h0000, host_irq}, 16'h0001); // irq raised
    host.wr(OFS_CTRL, 16'h0404);
    @(posedge sys_clk);
    #1;
    check({15'h0000, host_irq}, 16'h0000); // irq cleared
    host.swap();
    rchk(OFS_INDEX, 16'h0004); // count copied
    rchk(OFS_COUNT, 16'h0000); // count cleared
    rchk(OFS_EVT_CH, 16'h0103); // channel word
    rchk(OFS_EVT_CH + 14'h0004, 16'h0003); // falling level
    rchk(OFS_EVT_CH + 14'h0008, 16'h0004); // fall only
    rchk(OFS_EVT_CH + 14'h000C, 16'h0105); // fourth slot
    host.rd(OFS_EVT_TS, ts0);
    host.rd(OFS_EVT_TS + 14'h0004, v); // second slot timestamp
    check(v - ts0, 16'h0003); // timestamps in order
    $display("test change_log done");
    host.wr(OFS_CHCFG + 14'h000E, 16'h1C01);
    field_in[7] = 1'b1;
    wt(4);
    rchk(OFS_LEVEL, 16'h0080); // rise after debounce
    field_in[7] = 1'b0;
    wt(4);
    rchk(OFS_LEVEL, 16'h0080); // fall held off
    wt(6);
    rchk(OFS_LEVEL, 16'h0000); // fall accepted
    host.swap();
    rchk(OFS_INDEX, 16'h0002); // second bank logging
    rchk(OFS_EVT_CH, 16'h0107); // same layout
    $display("test ac_filter done");
    for (int c = 8; c < 16; c++) host.wr(OFS_CHCFG + 14'(2 * c), 16'h0C00);
    host.wr(OFS_MAXCNT, 16'h0002);
    host.wr(OFS_CTRL, 16'h0001);
    field_in[15:8] = 8'hFF;
    wt(3);
    rchk(OFS_CTRL, 16'h0501); // max flag
    check({15'h0000, host_irq}, 16'h0001); // max irq
    field_in[15:8] = 8'h00;
    wt(3);
    rchk(OFS_COUNT, 16'h0010); // full bank count
    field_in[9] = 1'b1;
    wt(3);
    rchk(OFS_COUNT, 16'h0001); // count rolled
    host.swap();
    rchk(OFS_EVT_CH, 16'h0109); // slot zero overwritten
    rchk(OFS_EVT_CH + 14'h0004, 16'h0109); // scan order
    rchk(OFS_EVT_CH + 14'h003C, 16'h000F); // last slot
    $display("test wrap done");
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    check({15'h0000, host_irq}, 16'h0000); // irq cleared by reset
    rchk(OFS_COUNT, 16'h0000); // count cleared by reset
    rchk(OFS_INDEX, 16'h0000); // index cleared by reset
    rchk(OFS_LEVEL, 16'h0000); // levels cleared by reset
    $display("test mid_reset done");
    conclude();
  end
endmodule
